// ### hbs_pkg.sv
// What this block does
// - Break alarm when heater current during on-time is below break threshold.
// - Break threshold 0.0 forces alarm off; 50.0 forces it on.
// - No break check for on-time up to 100 ms, 30 ms at short period.
// - Short alarm when off-time leakage exceeds short threshold.
// - Short threshold 50.0 forces alarm off; 0.0 forces it on.
// - No short check for off-time up to 100 ms, 35 ms at short period.
// - Leakage reading is taken while the heater output is off.
// - Readings span 0.0 to 55.0 A; above that they read FFFF.
// - Break threshold per channel, 0.0 to 50.0 A, reset to 0.0.
// - Short threshold per channel, 0.0 to 50.0 A, reset to 50.0.
// - Heater current display flashes while its break alarm is on.
// - Leakage display flashes while its short alarm is on.
// - Heater current and break thresholds work only with break enable on.
// - Leakage and short thresholds work only with short enable on.
// - Second channel exists only with two current sense inputs.
package hbs_pkg;
  localparam int NCH_MAX = 2;
  localparam int AMP_W = 16;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_BRK1 = 8'h04;
  localparam logic [ADDR_W-1:0] A_BRK2 = 8'h08;
  localparam logic [ADDR_W-1:0] A_SHT1 = 8'h0C;
  localparam logic [ADDR_W-1:0] A_SHT2 = 8'h10;
  localparam logic [ADDR_W-1:0] A_CUR1 = 8'h14;
  localparam logic [ADDR_W-1:0] A_CUR2 = 8'h18;
  localparam logic [ADDR_W-1:0] A_LEAK1 = 8'h1C;
  localparam logic [ADDR_W-1:0] A_LEAK2 = 8'h20;
  localparam logic [ADDR_W-1:0] A_ALARM = 8'h24;
  localparam logic [ADDR_W-1:0] A_ISTS = 8'h28;
  localparam logic [ADDR_W-1:0] A_ICLR = 8'h2C;
  localparam logic [ADDR_W-1:0] A_IEN = 8'h30;
  // Control register fields
  localparam int CTRL_BRK_EN = 0;
  localparam int CTRL_SHT_EN = 1;
  localparam int CTRL_FAST = 2;
  // Currents in 0.1 A steps
  localparam logic [AMP_W-1:0] AMP_ZERO = 16'h0000;
  localparam logic [AMP_W-1:0] TH_MAX = 16'h01F4;
  localparam logic [AMP_W-1:0] RANGE_MAX = 16'h0226;
  localparam logic [AMP_W-1:0] OVER_RANGE = 16'hFFFF;
  localparam logic [AMP_W-1:0] BRK_RST = 16'h0000;
  localparam logic [AMP_W-1:0] SHT_RST = 16'h01F4;
  // Timing
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned ON_MIN_MS = 100;
  localparam int unsigned ON_MIN_FAST_MS = 30;
  localparam int unsigned OFF_MIN_FAST_MS = 35;
  localparam int unsigned ON_MIN_CYC = ON_MIN_MS * CLK_KHZ;
  localparam int unsigned ON_FAST_CYC = ON_MIN_FAST_MS * CLK_KHZ;
  localparam int unsigned OFF_FAST_CYC = OFF_MIN_FAST_MS * CLK_KHZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [NCH_MAX-1:0][AMP_W-1:0] amps;
  } hbs_sample_t;

  typedef struct packed {
    logic [NCH_MAX-1:0] brk;
    logic [NCH_MAX-1:0] sht;
    logic [NCH_MAX-1:0] flash_heat;
    logic [NCH_MAX-1:0] flash_leak;
  } hbs_alarm_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } hbs_ahb_addr_t;
endpackage

// ### hbs_alarm_top.sv
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module hbs_alarm_top #(
  parameter bit TWO_CT = 1'b1,
  parameter int unsigned ON_MIN_CYCLES = hbs_pkg::ON_MIN_CYC,
  parameter int unsigned ON_FAST_CYCLES = hbs_pkg::ON_FAST_CYC,
  parameter int unsigned OFF_FAST_CYCLES = hbs_pkg::OFF_FAST_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire hbs_pkg::hbs_ahb_addr_t haddr_ph,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic heat_on,
  input wire logic sample_valid,
  input wire hbs_pkg::hbs_sample_t current_sense_input,
  output hbs_pkg::hbs_alarm_t alarms,
  output logic irq
);
  import hbs_pkg::*;

  localparam int NCH = TWO_CT ? 2 : 1;
  localparam logic [CNT_W-1:0] ON_LIM = CNT_W'(ON_MIN_CYCLES);
  localparam logic [CNT_W-1:0] ON_LIM_F = CNT_W'(ON_FAST_CYCLES);
  localparam logic [CNT_W-1:0] OFF_LIM_F = CNT_W'(OFF_FAST_CYCLES);
  localparam logic [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};
  localparam int EV_W = 2 * NCH_MAX;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [NCH_MAX-1:0][AMP_W-1:0] brk_th;
    logic [NCH_MAX-1:0][AMP_W-1:0] sht_th;
    logic [NCH_MAX-1:0][AMP_W-1:0] cur;
    logic [NCH_MAX-1:0][AMP_W-1:0] leak;
    logic [NCH_MAX-1:0] cur_vld;
    logic [NCH_MAX-1:0] leak_vld;
    logic heat_d;
    logic [CNT_W-1:0] run_cnt;
    logic [EV_W-1:0] ists;
    logic [EV_W-1:0] ien;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    hbs_alarm_t al;
    logic [31:0] rdata;
    logic irq;
  } hbs_state_t;

  hbs_state_t r;
  hbs_state_t n;

  // Values above the documented range read as the over-range marker
  function automatic logic [AMP_W-1:0] show(input logic [AMP_W-1:0] v);
    show = (v > RANGE_MAX) ? OVER_RANGE : v;
  endfunction

  function automatic logic [AMP_W-1:0] clamp_th(input logic [31:0] v);
    clamp_th = (v[31:AMP_W] != '0 || v[AMP_W-1:0] > TH_MAX) ? TH_MAX :
      v[AMP_W-1:0];
  endfunction

  // Word offset decode; unmapped offsets return 0 and ignore writes
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a <= A_IEN) && (a[1:0] == 2'h0);
  endfunction

  logic [CNT_W-1:0] on_lim;
  logic [CNT_W-1:0] off_lim;
  logic addr_ok;
  logic [ADDR_W-1:0] a_idx;

  always_comb begin
    on_lim = r.ctrl[CTRL_FAST] ? ON_LIM_F : ON_LIM;
    off_lim = r.ctrl[CTRL_FAST] ? OFF_LIM_F : ON_LIM;
    addr_ok = hsel && hready && haddr_ph.htrans == HTRANS_NONSEQ &&
      haddr_ph.hsize == HSIZE_WORD;
    a_idx = haddr_ph.haddr[ADDR_W-1:0];
  end

  always_comb begin
    logic [EV_W-1:0] ev;
    logic brk_en;
    logic sht_en;
    brk_en = 1'b0;
    sht_en = 1'b0;
    n = r;
    ev = '0;
    n.wr_pend = 1'b0;
    // Data phase of a write lands first so a read right behind sees it
    if (r.wr_pend) begin
      if (r.wr_addr == A_CTRL) begin
        n.ctrl = hwdata[2:0];
      end else if (r.wr_addr == A_BRK1) begin
        n.brk_th[0] = clamp_th(hwdata);
      end else if (r.wr_addr == A_BRK2 && NCH == 2) begin
        n.brk_th[1] = clamp_th(hwdata);
      end else if (r.wr_addr == A_SHT1) begin
        n.sht_th[0] = clamp_th(hwdata);
      end else if (r.wr_addr == A_SHT2 && NCH == 2) begin
        n.sht_th[1] = clamp_th(hwdata);
      end else if (r.wr_addr == A_ICLR) begin
        n.ists = r.ists & ~hwdata[EV_W-1:0];
      end else if (r.wr_addr == A_IEN) begin
        n.ien = hwdata[EV_W-1:0];
      end
    end
    brk_en = n.ctrl[CTRL_BRK_EN];
    sht_en = n.ctrl[CTRL_SHT_EN];
    // Heating output phase timer, restarts on each edge of the output
    n.heat_d = heat_on;
    if (heat_on != r.heat_d) begin
      n.run_cnt = '0;
    end else if (r.run_cnt != CNT_SAT) begin
      n.run_cnt = r.run_cnt + 1'b1;
    end
    for (int i = 0; i < NCH_MAX; i++) begin
      if (i < NCH) begin
        // Short pulses give unsettled readings, so they are skipped
        if (sample_valid && heat_on && r.heat_d && r.run_cnt > on_lim &&
            brk_en) begin
          n.cur[i] = show(current_sense_input.amps[i]);
          n.cur_vld[i] = 1'b1;
        end
        if (sample_valid && !heat_on && !r.heat_d && r.run_cnt > off_lim &&
            sht_en) begin
          n.leak[i] = show(current_sense_input.amps[i]);
          n.leak_vld[i] = 1'b1;
        end
        if (!brk_en) begin
          n.cur[i] = AMP_ZERO;
          n.cur_vld[i] = 1'b0;
        end
        if (!sht_en) begin
          n.leak[i] = AMP_ZERO;
          n.leak_vld[i] = 1'b0;
        end
        n.al.brk[i] = brk_en && n.brk_th[i] != AMP_ZERO &&
          (n.brk_th[i] == TH_MAX ||
           (n.cur_vld[i] && n.cur[i] < n.brk_th[i]));
        n.al.sht[i] = sht_en && n.sht_th[i] != TH_MAX &&
          (n.sht_th[i] == AMP_ZERO ||
           (n.leak_vld[i] && n.leak[i] > n.sht_th[i]));
      end else begin
        n.cur[i] = AMP_ZERO;
        n.leak[i] = AMP_ZERO;
        n.cur_vld[i] = 1'b0;
        n.leak_vld[i] = 1'b0;
        n.al.brk[i] = 1'b0;
        n.al.sht[i] = 1'b0;
      end
    end
    n.al.flash_heat = n.al.brk;
    n.al.flash_leak = n.al.sht;
    ev = {n.al.sht & ~r.al.sht, n.al.brk & ~r.al.brk};
    // Set beats a clear that lands in the same cycle
    n.ists = n.ists | ev;
    n.irq = |(n.ists & n.ien);
    // Address phase
    n.rdata = '0;
    if (addr_ok && haddr_ph.hwrite && mapped(a_idx)) begin
      n.wr_pend = 1'b1;
      n.wr_addr = a_idx;
    end else if (addr_ok && !haddr_ph.hwrite && mapped(a_idx)) begin
      if (a_idx == A_CTRL) begin
        n.rdata = {29'h0, n.ctrl};
      end else if (a_idx == A_BRK1) begin
        n.rdata = {16'h0, n.brk_th[0]};
      end else if (a_idx == A_BRK2) begin
        n.rdata = {16'h0, n.brk_th[1]};
      end else if (a_idx == A_SHT1) begin
        n.rdata = {16'h0, n.sht_th[0]};
      end else if (a_idx == A_SHT2) begin
        n.rdata = {16'h0, n.sht_th[1]};
      end else if (a_idx == A_CUR1) begin
        n.rdata = {16'h0, n.cur[0]};
      end else if (a_idx == A_CUR2) begin
        n.rdata = {16'h0, n.cur[1]};
      end else if (a_idx == A_LEAK1) begin
        n.rdata = {16'h0, n.leak[0]};
      end else if (a_idx == A_LEAK2) begin
        n.rdata = {16'h0, n.leak[1]};
      end else if (a_idx == A_ALARM) begin
        n.rdata = {28'h0, n.al.sht, n.al.brk};
      end else if (a_idx == A_ISTS) begin
        n.rdata = {28'h0, n.ists};
      end else if (a_idx == A_IEN) begin
        n.rdata = {28'h0, n.ien};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.brk_th <= {NCH_MAX{BRK_RST}};
      r.sht_th <= {NCH_MAX{SHT_RST}};
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata = r.rdata;
  // Zero-wait slave; ce low still answers so the bus never hangs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign alarms = r.al;
  assign irq = r.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_brk_zero_off: assert property (r.brk_th[0] == AMP_ZERO |-> !alarms.brk[0])
    else $error("break alarm on with zero threshold");
  a_brk_max_on: assert property (r.brk_th[0] == TH_MAX && r.ctrl[CTRL_BRK_EN]
    |-> alarms.brk[0])
    else $error("break alarm off with full threshold");
  a_brk_low_cur: assert property (r.ctrl[CTRL_BRK_EN] && r.cur_vld[0] &&
    r.brk_th[0] != AMP_ZERO && r.cur[0] < r.brk_th[0] |-> alarms.brk[0])
    else $error("break alarm missing on low current");
  a_sht_max_off: assert property (r.sht_th[1] == TH_MAX |-> !alarms.sht[1])
    else $error("short alarm on with full threshold");
  a_sht_high_leak: assert property (r.ctrl[CTRL_SHT_EN] && r.leak_vld[0] &&
    r.sht_th[0] != TH_MAX && r.leak[0] > r.sht_th[0] |-> alarms.sht[0])
    else $error("short alarm missing on high leakage");
  a_cur_range: assert property (r.cur[0] <= RANGE_MAX || r.cur[0] == OVER_RANGE)
    else $error("heater current outside range");
  a_th_range: assert property (r.brk_th[1] <= TH_MAX && r.sht_th[0] <= TH_MAX)
    else $error("threshold above limit");
  a_flash_follow: assert property (alarms.flash_heat == alarms.brk &&
    alarms.flash_leak == alarms.sht)
    else $error("flash does not follow alarm");
  a_brk_disabled: assert property (!r.ctrl[CTRL_BRK_EN] |-> !alarms.brk[0]
    && r.cur[0] == AMP_ZERO)
    else $error("break path active while disabled");
  a_sht_disabled: assert property (!r.ctrl[CTRL_SHT_EN] |-> !alarms.sht[1]
    && r.leak[1] == AMP_ZERO)
    else $error("short path active while disabled");
  a_cur_late: assert property (ce && !r.cur_vld[0] ##1 r.cur_vld[0] |->
    $past(r.run_cnt) > $past(on_lim) && $past(heat_on))
    else $error("heater current taken too early");
  a_leak_off: assert property (ce && !r.leak_vld[0] ##1 r.leak_vld[0] |->
    !$past(heat_on) && $past(r.run_cnt) > $past(off_lim))
    else $error("leakage taken while heater on or too early");
  a_irq_level: assert property (ce |=> irq == |(r.ists & r.ien))
    else $error("interrupt does not match status");

  // Mirrors of the checks above for the other channel, plus zero-threshold short, leakage range and one-input checks, since the bench forces levels there
  a_brk2_zero_off: assert property (r.brk_th[1] == AMP_ZERO |-> !alarms.brk[1])
    else $error("break alarm 2 on with zero threshold");

  a_brk2_max_on: assert property (r.brk_th[1] == TH_MAX && r.ctrl[CTRL_BRK_EN]
    |-> alarms.brk[1])
    else $error("break alarm 2 off with full threshold");

  a_brk2_low_cur: assert property (r.ctrl[CTRL_BRK_EN] && r.cur_vld[1] &&
    r.brk_th[1] != AMP_ZERO && r.cur[1] < r.brk_th[1] |-> alarms.brk[1])
    else $error("break alarm 2 missing on low current");

  a_sht1_max_off: assert property (r.sht_th[0] == TH_MAX |-> !alarms.sht[0])
    else $error("short alarm 1 on with full threshold");

  a_sht1_zero_on: assert property (r.sht_th[0] == AMP_ZERO && r.ctrl[CTRL_SHT_EN]
    |-> alarms.sht[0])
    else $error("short alarm 1 off with zero threshold");

  a_sht2_zero_on: assert property (r.sht_th[1] == AMP_ZERO && r.ctrl[CTRL_SHT_EN]
    |-> alarms.sht[1])
    else $error("short alarm 2 off with zero threshold");

  a_sht2_high_leak: assert property (r.ctrl[CTRL_SHT_EN] && r.leak_vld[1] &&
    r.sht_th[1] != TH_MAX && r.leak[1] > r.sht_th[1] |-> alarms.sht[1])
    else $error("short alarm 2 missing on high leakage");

  a_cur2_range: assert property (r.cur[1] <= RANGE_MAX || r.cur[1] == OVER_RANGE)
    else $error("heater current 2 outside range");

  a_leak_range: assert property ((r.leak[0] <= RANGE_MAX ||
    r.leak[0] == OVER_RANGE) && (r.leak[1] <= RANGE_MAX ||
    r.leak[1] == OVER_RANGE))
    else $error("leakage outside range");

  a_brk_th_range: assert property (r.brk_th[0] <= TH_MAX &&
    r.sht_th[1] <= TH_MAX)
    else $error("threshold above limit");

  a_brk2_disabled: assert property (!r.ctrl[CTRL_BRK_EN] |-> !alarms.brk[1]
    && r.cur[1] == AMP_ZERO)
    else $error("break path 2 active while disabled");

  a_sht1_disabled: assert property (!r.ctrl[CTRL_SHT_EN] |-> !alarms.sht[0]
    && r.leak[0] == AMP_ZERO)
    else $error("short path 1 active while disabled");

  a_one_ct_quiet: assert property (!TWO_CT |-> !alarms.brk[1] &&
    !alarms.sht[1])
    else $error("second channel alarm without second input");
endmodule // hbs_alarm_top

// ### hbs_ct_model.sv
`timescale 1ns/1ns
module hbs_ct_model
  import hbs_pkg::*;
(
  input wire logic hclk,
  output logic heat_on,
  output logic sample_valid,
  output hbs_sample_t current_sense_input
);
  initial begin
    heat_on = 1'b0;
    sample_valid = 1'b0;
    current_sense_input = '0;
  end

  // One heating phase, a fresh sample every other cycle in 0.1 A steps
  task automatic phase(input logic on, input int n,
                       input logic [AMP_W-1:0] a1, input logic [AMP_W-1:0] a2);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      heat_on <= on;
      sample_valid <= 1'b1;
      current_sense_input <= {a2, a1};
      @(posedge hclk);
      sample_valid <= 1'b0;
      // Data not valid between strobes, so never leave the last value up
      current_sense_input <= ~{a2, a1};
    end
  endtask
endmodule // hbs_ct_model

// ### hbs_alarm_top_tb.sv
`timescale 1ns/1ns
module hbs_alarm_top_tb;
  import hbs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  hbs_ahb_addr_t addr_ph = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic heat_on;
  logic sample_valid;
  hbs_sample_t cur;
  hbs_alarm_t alarms;
  logic irq;
  logic [31:0] q;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 hclk = ~hclk;

  hbs_alarm_top #(.TWO_CT(1'b1), .ON_MIN_CYCLES(20), .ON_FAST_CYCLES(6),
    .OFF_FAST_CYCLES(7)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr_ph(addr_ph), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .heat_on(heat_on), .sample_valid(sample_valid),
    .current_sense_input(cur), .alarms(alarms), .irq(irq));

  hbs_ct_model u_ct (.hclk(hclk), .heat_on(heat_on),
    .sample_valid(sample_valid), .current_sense_input(cur));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    addr_ph <= '{HTRANS_NONSEQ, {24'h000000, a}, w, HSIZE_WORD};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    addr_ph.htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    bus(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_BRK1, 32'h0, "brk1 reset");
    rd(A_BRK2, 32'h0, "brk2 reset");
    rd(A_SHT1, 32'h1F4, "sht1 reset");
    rd(A_SHT2, 32'h1F4, "sht2 reset");
    rd(8'h34, 32'h0, "unmapped");
    wr(A_BRK1, 32'h300);
    rd(A_BRK1, 32'h1F4, "brk clamp");
    ce <= 1'b0;
    wr(A_BRK1, 32'h77);
    ce <= 1'b1;
    rd(A_BRK1, 32'h1F4, "frozen write");
    $display("test registers done");
    wr(A_CTRL, 32'h3);
    wr(A_BRK1, 32'h64);
    wr(A_BRK2, 32'h64);
    wr(A_SHT1, 32'h32);
    wr(A_SHT2, 32'h32);
    u_ct.phase(1'b1, 7, 16'h0050, 16'h00C8);
    rd(A_CUR1, 32'h0, "short on-time");
    u_ct.phase(1'b0, 15, 16'h003C, 16'h000A);
    rd(A_LEAK1, 32'h3C, "leak1");
    rd(A_LEAK2, 32'h0A, "leak2");
    u_ct.phase(1'b1, 15, 16'h0050, 16'h00C8);
    rd(A_CUR1, 32'h50, "cur1");
    rd(A_CUR2, 32'hC8, "cur2");
    rd(A_ALARM, 32'h5, "break and short");
    chk({24'h0, alarms}, 32'h55, "flash");
    u_ct.phase(1'b1, 3, 16'h0258, 16'h0226);
    rd(A_CUR1, 32'hFFFF, "over range");
    rd(A_CUR2, 32'h226, "range top");
    rd(A_ALARM, 32'h4, "over range no break");
    $display("test readings done");
    wr(A_CTRL, 32'h7);
    // Sample must land after more than the fast off limit
    u_ct.phase(1'b0, 6, 16'h0046, 16'h0000);
    rd(A_LEAK1, 32'h46, "fast off-time");
    u_ct.phase(1'b1, 5, 16'h005A, 16'h005A);
    rd(A_CUR1, 32'h5A, "fast on-time");
    $display("test fast period done");
    wr(A_BRK1, 32'h0);
    wr(A_BRK2, 32'h1F4);
    wr(A_SHT1, 32'h1F4);
    wr(A_SHT2, 32'h0);
    rd(A_ALARM, 32'hA, "forced levels");
    chk({24'h0, alarms}, 32'hAA, "forced flash");
    $display("test thresholds done");
    wr(A_ICLR, 32'hF);
    rd(A_ISTS, 32'h0, "status cleared");
    rd(A_ICLR, 32'h0, "clear reads zero");
    wr(A_IEN, 32'h4);
    wr(A_SHT1, 32'h0);
    rd(A_ISTS, 32'h4, "status sticky");
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(A_IEN, 32'h0);
    // Mask lands on the last bus edge; irq drops on that same edge
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(A_ICLR, 32'h4);
    rd(A_ISTS, 32'h0, "status clear");
    $display("test interrupt done");
    wr(A_CTRL, 32'h0);
    rd(A_CUR1, 32'h0, "break disabled");
    rd(A_LEAK1, 32'h0, "short disabled");
    rd(A_ALARM, 32'h0, "alarms disabled");
    $display("test disable done");
    end_of_test();
  end
endmodule // hbs_alarm_top_tb
